// File: pkg/bar_hdr_pkg.sv
// Offsets, field positions and reset values of the base address header slice.
package bar_hdr_pkg;

	// Byte offsets, identical on the PCI configuration port and the local port.
	localparam logic [7:0] OFF_MEM_BASE_INT = 8'h10;
	localparam logic [7:0] OFF_IO_BASE_INT = 8'h14;
	localparam logic [7:0] OFF_SPACE0_BASE = 8'h18;
	localparam logic [7:0] OFF_SPACE1_BASE = 8'h1C;
	localparam logic [7:0] OFF_SLOT_FOUR = 8'h20;
	localparam logic [7:0] OFF_SLOT_FIVE = 8'h24;
	localparam logic [7:0] OFF_CARD_INFO = 8'h28;
	localparam logic [7:0] OFF_SUBSYS_VENDOR = 8'h2C;

	// Field positions in the base registers and the local control words.
	localparam int SPACE_IND_BIT = 0;
	localparam int LOC_LSB = 1;
	localparam int LOC_MSB = 2;
	localparam int PREFETCH_BIT = 3;
	localparam int DECODE_EN_BIT = 0;
	localparam int QUEUE_HIDE_BIT = 0;

	// Writable masks of the base registers.
	localparam logic [31:0] INT_BASE_WMASK = 32'hFFFFFF00;
	localparam logic [31:0] MEM_SPACE_WMASK = 32'hFFFFFFF0;
	localparam logic [31:0] IO_SPACE_WMASK = 32'hFFFFFFFC;

	// Constant reads and reset values.
	localparam logic [31:0] BASE_RESET = 32'h00000000;
	localparam logic [31:0] ZERO_WORD = 32'h00000000;
	localparam logic [31:0] IO_INDICATOR = 32'h00000001;
	localparam int SVID_WIDTH = 16;

	// Decode windows, in the order of the claim outputs.
	localparam int NUM_WIN = 4;
	typedef enum logic [1:0] {
		WIN_MEM_INT,
		WIN_IO_INT,
		WIN_SPACE0,
		WIN_SPACE1
	} win_type;

endpackage

// File: rtl/bar_window_match.sv
// Address match of one base address window against a bus address.
`timescale 1ns/1ps
module bar_window_match #(
	parameter int ADDR_WIDTH = 32
) (
	// Access under test.
	input wire logic [ADDR_WIDTH-1:0] addr_in,
	input wire logic addr_is_io_in,
	// Window programming.
	input wire logic [ADDR_WIDTH-1:0] base_in,
	input wire logic [ADDR_WIDTH-1:0] mask_in,
	input wire logic win_is_io_in,
	input wire logic enable_in,
	// Result.
	output logic hit_out
);

	// A hit needs a matching space, the enable set and equal masked bits.
	always_comb begin
		hit_out = enable_in && (addr_is_io_in == win_is_io_in) &&
			(((addr_in ^ base_in) & mask_in) == '0);
	end

endmodule

// File: rtl/pci_bar_config_header.sv
// Base address slice of the type-0 configuration header, offsets 10h to 2Ch.
`timescale 1ns/1ps
module pci_bar_config_header #(
	parameter logic [15:0] SVID_RESET = 16'h5A5A // Arbitrary neutral value.
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic srst_in,
	// PCI configuration port.
	input wire logic cfg_sel_in,
	input wire logic cfg_wr_in,
	input wire logic [7:0] cfg_addr_in,
	input wire logic [3:0] cfg_be_in,
	input wire logic [31:0] cfg_wdata_in,
	output logic [31:0] cfg_rdata_out,
	output logic cfg_ack_out,
	// Local processor register port.
	input wire logic loc_sel_in,
	input wire logic loc_wr_in,
	input wire logic [7:0] loc_addr_in,
	input wire logic [3:0] loc_be_in,
	input wire logic [31:0] loc_wdata_in,
	output logic [31:0] loc_rdata_out,
	output logic loc_ack_out,
	// Serial configuration memory load of the subsystem vendor id.
	input wire logic eeprom_svid_load_in,
	input wire logic [15:0] eeprom_svid_in,
	// Local range, enable and queue status words kept elsewhere.
	input wire logic [31:0] space0_range_cfg_in,
	input wire logic [31:0] space1_range_cfg_in,
	input wire logic [31:0] space0_local_base_cfg_in,
	input wire logic [31:0] space1_local_base_cfg_in,
	input wire logic [31:0] local_misc_control_one_in,
	input wire logic [31:0] message_queue_status_in,
	// PCI address phase to be decoded.
	input wire logic bus_req_in,
	input wire logic [31:0] bus_addr_in,
	input wire logic bus_is_io_in,
	// Claims, one per window in win_type order.
	output logic [3:0] claim_out,
	// Current subsystem vendor id.
	output logic [15:0] svid_out
);

	// Both register ports reach every register at the same offset. Reads take the
	// registers as they stood before the edge, so a read and a write of one offset
	// in one cycle return the old word and the write shows from the next access on.
	// When both ports write one register in one cycle, the host write is applied
	// first and the local write second, so firmware wins on every byte it enables.
	// The vendor id never takes host writes; a serial memory load beats a local
	// write in the same cycle, so a load at power-up cannot be lost to firmware.
	// The mirror bits of the space registers are read live from the range words:
	// a new range word shows on the next read with no write to the base register,
	// and a change from memory to I/O widens the writable field down to bit 2.
	// The stored base bits below the writable field are kept but never shown, and
	// the matchers mask them off as well, so stale low bits can never cause a hit.
	// The prefetch bit is status for software only and never reaches the matchers.
	// Claims are registered, so a hit is reported one cycle after the address
	// phase that caused it; a window disabled in that phase reports no hit.

	// Every piece of state of the block.
	typedef struct packed {
		logic [31:0] mem_int_base;
		logic [31:0] io_int_base;
		logic [31:0] space0_base;
		logic [31:0] space1_base;
		logic [15:0] svid;
		logic [31:0] cfg_rdata;
		logic cfg_ack;
		logic [31:0] loc_rdata;
		logic loc_ack;
		logic [3:0] claim;
	} state_type;

	state_type state_reg;
	state_type state_next;
	logic [3:0] hit;
	logic [31:0] win_base [4];
	logic [31:0] win_mask [4];
	logic [3:0] win_io;
	logic [3:0] win_en;
	logic space1_hidden;

	// The queue status bit hides the space 1 base on both ports alike.
	assign space1_hidden = message_queue_status_in[bar_hdr_pkg::QUEUE_HIDE_BIT];

	// Merges enabled bytes of a write into the writable bits of a register.
	function automatic logic [31:0] merge_write(input logic [31:0] old_val,
		input logic [31:0] wdata, input logic [3:0] be, input logic [31:0] wmask);
		logic [31:0] lane;
		lane = '0;
		for (int i = 0; i < 4; i++) begin
			lane[i*8 +: 8] = {8{be[i]}};
		end
		return (old_val & ~(lane & wmask)) | (wdata & lane & wmask);
	endfunction

	// Writable mask of a local space base register, set by its range word.
	function automatic logic [31:0] space_wmask(input logic [31:0] range_cfg);
		if (range_cfg[bar_hdr_pkg::SPACE_IND_BIT]) begin
			return bar_hdr_pkg::IO_SPACE_WMASK;
		end else begin
			return bar_hdr_pkg::MEM_SPACE_WMASK;
		end
	endfunction

	// Compare mask of a local space window: range ones within the writable bits.
	function automatic logic [31:0] space_win_mask(input logic [31:0] range_cfg);
		return range_cfg & space_wmask(range_cfg);
	endfunction

	// Read request of a register port: selected and not writing.
	function automatic logic is_rd_req(input logic sel, input logic wr);
		return sel && !wr;
	endfunction

	// Write request of a register port: selected and writing.
	function automatic logic is_wr_req(input logic sel, input logic wr);
		return sel && wr;
	endfunction

	// Local write of the vendor id: only byte lanes 0 and 1 carry it.
	function automatic logic [15:0] svid_write(input logic [15:0] old_val,
		input logic [31:0] wdata, input logic [3:0] be);
		logic [31:0] merged;
		merged = merge_write({16'h0000, old_val}, wdata, be, 32'h0000FFFF);
		return merged[15:0];
	endfunction

	// Read view of an internal register window: a 256-byte block plus its space bit.
	function automatic logic [31:0] int_view(input logic [31:0] base,
		input logic [31:0] indicator);
		return (base & bar_hdr_pkg::INT_BASE_WMASK) | indicator;
	endfunction

	// Read view of a local space base register.
	function automatic logic [31:0] space_view(input logic [31:0] base,
		input logic [31:0] range_cfg);
		logic [31:0] v;
		v = base & space_wmask(range_cfg);
		if (range_cfg[bar_hdr_pkg::SPACE_IND_BIT]) begin
			v[bar_hdr_pkg::SPACE_IND_BIT] = 1'b1;
			v[bar_hdr_pkg::LOC_LSB] = 1'b0;
		end else begin
			v[bar_hdr_pkg::SPACE_IND_BIT] = 1'b0;
			v[bar_hdr_pkg::LOC_MSB:bar_hdr_pkg::LOC_LSB] =
				range_cfg[bar_hdr_pkg::LOC_MSB:bar_hdr_pkg::LOC_LSB];
			v[bar_hdr_pkg::PREFETCH_BIT] = range_cfg[bar_hdr_pkg::PREFETCH_BIT];
		end
		return v;
	endfunction

	// Read mux shared by both ports, so every offset answers alike on each.
	function automatic logic [31:0] read_word(input logic [7:0] off, input state_type s,
		input logic [31:0] rr0, input logic [31:0] rr1, input logic hide1);
		case (off)
			bar_hdr_pkg::OFF_MEM_BASE_INT: begin
				return int_view(s.mem_int_base, bar_hdr_pkg::ZERO_WORD);
			end
			bar_hdr_pkg::OFF_IO_BASE_INT: begin
				return int_view(s.io_int_base, bar_hdr_pkg::IO_INDICATOR);
			end
			bar_hdr_pkg::OFF_SPACE0_BASE: begin
				return space_view(s.space0_base, rr0);
			end
			bar_hdr_pkg::OFF_SPACE1_BASE: begin
				if (hide1) begin
					return bar_hdr_pkg::ZERO_WORD;
				end else begin
					return space_view(s.space1_base, rr1);
				end
			end
			bar_hdr_pkg::OFF_SLOT_FOUR, bar_hdr_pkg::OFF_SLOT_FIVE: begin
				return bar_hdr_pkg::ZERO_WORD;
			end
			bar_hdr_pkg::OFF_CARD_INFO: begin
				return bar_hdr_pkg::ZERO_WORD;
			end
			bar_hdr_pkg::OFF_SUBSYS_VENDOR: begin
				return {{(32 - bar_hdr_pkg::SVID_WIDTH){1'b0}}, s.svid};
			end
			default: begin
				return bar_hdr_pkg::ZERO_WORD;
			end
		endcase
	endfunction

	// Applies one port's write to the base registers. Constant slots drop it.
	function automatic state_type apply_write(input state_type s, input logic [7:0] off,
		input logic [3:0] be, input logic [31:0] wdata, input logic [31:0] rr0,
		input logic [31:0] rr1);
		state_type r;
		r = s;
		case (off)
			bar_hdr_pkg::OFF_MEM_BASE_INT: begin
				r.mem_int_base = merge_write(s.mem_int_base, wdata, be,
					bar_hdr_pkg::INT_BASE_WMASK);
			end
			bar_hdr_pkg::OFF_IO_BASE_INT: begin
				r.io_int_base = merge_write(s.io_int_base, wdata, be,
					bar_hdr_pkg::INT_BASE_WMASK);
			end
			bar_hdr_pkg::OFF_SPACE0_BASE: begin
				r.space0_base = merge_write(s.space0_base, wdata, be,
					space_wmask(rr0));
			end
			bar_hdr_pkg::OFF_SPACE1_BASE: begin
				r.space1_base = merge_write(s.space1_base, wdata, be,
					space_wmask(rr1));
			end
			default: begin
				r = s;
			end
		endcase
		return r;
	endfunction

	// Window programming handed to the address matchers.
	always_comb begin
		// Internal memory window: its enable lives in the command register outside.
		win_base[bar_hdr_pkg::WIN_MEM_INT] = state_reg.mem_int_base;
		win_mask[bar_hdr_pkg::WIN_MEM_INT] = bar_hdr_pkg::INT_BASE_WMASK;
		win_io[bar_hdr_pkg::WIN_MEM_INT] = 1'b0;
		win_en[bar_hdr_pkg::WIN_MEM_INT] = 1'b1;

		// Internal I/O window: switched by the local miscellaneous control word.
		win_base[bar_hdr_pkg::WIN_IO_INT] = state_reg.io_int_base;
		win_mask[bar_hdr_pkg::WIN_IO_INT] = bar_hdr_pkg::INT_BASE_WMASK;
		win_io[bar_hdr_pkg::WIN_IO_INT] = 1'b1;
		win_en[bar_hdr_pkg::WIN_IO_INT] =
			local_misc_control_one_in[bar_hdr_pkg::DECODE_EN_BIT];

		// Local space 0 window: size and space type come from its range word.
		win_base[bar_hdr_pkg::WIN_SPACE0] = state_reg.space0_base;
		win_mask[bar_hdr_pkg::WIN_SPACE0] = space_win_mask(space0_range_cfg_in);
		win_io[bar_hdr_pkg::WIN_SPACE0] = space0_range_cfg_in[bar_hdr_pkg::SPACE_IND_BIT];
		win_en[bar_hdr_pkg::WIN_SPACE0] =
			space0_local_base_cfg_in[bar_hdr_pkg::DECODE_EN_BIT];

		// Local space 1 window, built the same way from its own words.
		win_base[bar_hdr_pkg::WIN_SPACE1] = state_reg.space1_base;
		win_mask[bar_hdr_pkg::WIN_SPACE1] = space_win_mask(space1_range_cfg_in);
		win_io[bar_hdr_pkg::WIN_SPACE1] = space1_range_cfg_in[bar_hdr_pkg::SPACE_IND_BIT];
		win_en[bar_hdr_pkg::WIN_SPACE1] =
			space1_local_base_cfg_in[bar_hdr_pkg::DECODE_EN_BIT];
	end

	// One matcher per window; the prefetch bit takes no part in decoding.
	generate
		for (genvar w = 0; w < bar_hdr_pkg::NUM_WIN; w++) begin : g_win
			bar_window_match #(
				.ADDR_WIDTH(32)
			) u_match (
				.addr_in(bus_addr_in),
				.addr_is_io_in(bus_is_io_in),
				.base_in(win_base[w]),
				.mask_in(win_mask[w]),
				.win_is_io_in(win_io[w]),
				.enable_in(win_en[w]),
				.hit_out(hit[w])
			);
		end
	endgenerate

	// Next state: port writes, vendor id loads, read data and claims.
	always_comb begin
		state_next = state_reg;
		state_next.cfg_ack = cfg_sel_in;
		state_next.loc_ack = loc_sel_in;
		// Reads see the registers as they stand before this cycle's writes.
		if (is_rd_req(cfg_sel_in, cfg_wr_in)) begin
			state_next.cfg_rdata = read_word(cfg_addr_in, state_reg, space0_range_cfg_in,
				space1_range_cfg_in, space1_hidden);
		end
		if (is_rd_req(loc_sel_in, loc_wr_in)) begin
			state_next.loc_rdata = read_word(loc_addr_in, state_reg, space0_range_cfg_in,
				space1_range_cfg_in, space1_hidden);
		end
		// PCI write first; a local write in the same cycle wins on shared bytes.
		if (is_wr_req(cfg_sel_in, cfg_wr_in)) begin
			state_next = apply_write(state_next, cfg_addr_in, cfg_be_in, cfg_wdata_in,
				space0_range_cfg_in, space1_range_cfg_in);
		end
		if (is_wr_req(loc_sel_in, loc_wr_in)) begin
			state_next = apply_write(state_next, loc_addr_in, loc_be_in, loc_wdata_in,
				space0_range_cfg_in, space1_range_cfg_in);
			if (loc_addr_in == bar_hdr_pkg::OFF_SUBSYS_VENDOR) begin
				state_next.svid = svid_write(state_reg.svid, loc_wdata_in, loc_be_in);
			end
		end
		// The serial memory load overrides a local write in the same cycle.
		if (eeprom_svid_load_in) begin
			state_next.svid = eeprom_svid_in;
		end
		// Claims are registered one cycle after the address phase.
		state_next.claim = bus_req_in ? hit : 4'h0;
	end

	// State register.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_reg.mem_int_base <= bar_hdr_pkg::BASE_RESET;
			state_reg.io_int_base <= bar_hdr_pkg::BASE_RESET;
			state_reg.space0_base <= bar_hdr_pkg::BASE_RESET;
			state_reg.space1_base <= bar_hdr_pkg::BASE_RESET;
			state_reg.svid <= SVID_RESET;
			state_reg.cfg_rdata <= bar_hdr_pkg::ZERO_WORD;
			state_reg.cfg_ack <= 1'b0;
			state_reg.loc_rdata <= bar_hdr_pkg::ZERO_WORD;
			state_reg.loc_ack <= 1'b0;
			state_reg.claim <= 4'h0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from the state register.
	assign cfg_rdata_out = state_reg.cfg_rdata;
	assign cfg_ack_out = state_reg.cfg_ack;
	assign loc_rdata_out = state_reg.loc_rdata;
	assign loc_ack_out = state_reg.loc_ack;
	assign claim_out = state_reg.claim;
	assign svid_out = state_reg.svid;

endmodule

// File: verif/reg_host_model.sv
// Behavioural register master standing in for host software or the local processor.
`timescale 1ns/1ps
module reg_host_model (
	// Clock.
	input wire logic clk_in,
	// Request lines.
	output logic sel_out,
	output logic wr_out,
	output logic [7:0] addr_out,
	output logic [3:0] be_out,
	output logic [31:0] wdata_out,
	// Answer lines.
	input wire logic [31:0] rdata_in,
	input wire logic ack_in
);
	// Nothing is requested until the first transfer.
	initial begin
		sel_out = 1'b0;
		wr_out = 1'b0;
		addr_out = 8'h00;
		be_out = 4'h0;
		wdata_out = 32'h00000000;
	end

	// One access: a single-cycle request, answer taken one cycle later.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] b,
		input logic [31:0] d, output logic [31:0] q);
		@(negedge clk_in);
		sel_out = 1'b1; // Same offsets on either port.
		wr_out = w;
		addr_out = a;
		be_out = b;
		wdata_out = d;
		@(negedge clk_in);
		q = ack_in ? rdata_in : 32'hXXXXXXXX;
		sel_out = 1'b0;
		// Released address and data lines carry stale garbage, not the last value.
		addr_out = ~a;
		wdata_out = ~d;
	endtask
endmodule

// File: verif/pci_bar_config_header_sva.sv
// Port-level assertions for the base address header slice.
`timescale 1ns/1ps
module pci_bar_config_header_sva (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic cfg_sel_in,
	input wire logic cfg_wr_in,
	input wire logic [7:0] cfg_addr_in,
	input wire logic [31:0] cfg_rdata_out,
	input wire logic cfg_ack_out,
	input wire logic loc_sel_in,
	input wire logic loc_ack_out,
	input wire logic eeprom_svid_load_in,
	input wire logic [15:0] eeprom_svid_in,
	input wire logic [31:0] space0_range_cfg_in,
	input wire logic [31:0] space0_local_base_cfg_in,
	input wire logic [31:0] space1_local_base_cfg_in,
	input wire logic [31:0] local_misc_control_one_in,
	input wire logic [31:0] message_queue_status_in,
	input wire logic bus_req_in,
	input wire logic [3:0] claim_out,
	input wire logic [15:0] svid_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);

	// A configuration read of one offset.
	sequence cfg_rd_s(logic [7:0] a);
		cfg_sel_in && !cfg_wr_in && cfg_addr_in == a;
	endsequence

	// Acknowledge timing and the fixed and mirrored read fields.
	cfg_ack_a: assert property (cfg_ack_out == $past(cfg_sel_in))
		else $error("config ack timing wrong");
	loc_ack_a: assert property (loc_sel_in |=> loc_ack_out)
		else $error("local ack missing");
	io_low_a: assert property (cfg_rd_s(8'h14) |=> cfg_rdata_out[7:0] == 8'h01)
		else $error("io base low byte wrong");
	mem_low_a: assert property (cfg_rd_s(8'h10) |=> cfg_rdata_out[7:0] == 8'h00)
		else $error("memory base low byte wrong");
	rsvd_zero_a: assert property ((cfg_rd_s(8'h20) or cfg_rd_s(8'h24) or cfg_rd_s(8'h28))
		|=> cfg_rdata_out == 32'h00000000) else $error("reserved slot not zero");
	queue_hide_a: assert property (cfg_rd_s(8'h1C) ##0 message_queue_status_in[0]
		|=> cfg_rdata_out == 32'h00000000) else $error("space1 base not hidden");
	mem_mirror_a: assert property (cfg_rd_s(8'h18) ##0 !space0_range_cfg_in[0]
		|=> cfg_rdata_out[3:0] == {$past(space0_range_cfg_in[3:1]), 1'b0}) else $error("mirror bits wrong");
	io_mirror_a: assert property (cfg_rd_s(8'h18) ##0 space0_range_cfg_in[0]
		|=> cfg_rdata_out[1:0] == 2'b01) else $error("io space low bits wrong");

	// Disabled windows and idle cycles claim nothing.
	io_off_a: assert property (bus_req_in && !local_misc_control_one_in[0] |=> !claim_out[1])
		else $error("disabled io window claimed");
	sp0_off_a: assert property (bus_req_in && !space0_local_base_cfg_in[0] |=> !claim_out[2])
		else $error("disabled space0 claimed");
	sp1_off_a: assert property (bus_req_in && !space1_local_base_cfg_in[0] |=> !claim_out[3])
		else $error("disabled space1 claimed");
	idle_claim_a: assert property (!bus_req_in |=> claim_out == 4'h0)
		else $error("claim without request");

	// Vendor id loads from the serial memory, never from a PCI write.
	svid_load_a: assert property (eeprom_svid_load_in |=> svid_out == $past(eeprom_svid_in))
		else $error("vendor id load lost");
	svid_pci_a: assert property (cfg_sel_in && cfg_wr_in && cfg_addr_in == 8'h2C && !loc_sel_in
		&& !eeprom_svid_load_in |=> $stable(svid_out)) else $error("PCI wrote vendor id");
endmodule

// File: verif/test_pci_bar_config_header.sv
// Self-checking bench for the base address header slice.
`timescale 1ns/1ps
module test_pci_bar_config_header;
	localparam logic [15:0] SVID = 16'h3C3C; // Arbitrary value.
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic cfg_sel_in, cfg_wr_in, cfg_ack_out, loc_sel_in, loc_wr_in, loc_ack_out;
	logic [7:0] cfg_addr_in, loc_addr_in;
	logic [3:0] cfg_be_in, loc_be_in, claim_out;
	logic [31:0] cfg_wdata_in, cfg_rdata_out, loc_wdata_in, loc_rdata_out;
	logic eeprom_svid_load_in = 1'b0;
	logic [15:0] eeprom_svid_in = 16'h1234;
	logic [15:0] svid_out;
	logic [31:0] space0_range_cfg_in = 32'hFFFF000A;
	logic [31:0] space1_range_cfg_in = 32'hFFFFFF01;
	logic [31:0] space0_local_base_cfg_in = 32'h0, space1_local_base_cfg_in = 32'h0;
	logic [31:0] local_misc_control_one_in = 32'h0, message_queue_status_in = 32'h0;
	logic bus_req_in = 1'b0;
	logic bus_is_io_in = 1'b0;
	logic [31:0] bus_addr_in = 32'h0;
	int fail_count = 0;
	int checks_done = 0;

	// Design and the two masters facing its register ports.
	pci_bar_config_header #(.SVID_RESET(SVID)) u_pci_bar_config_header (.*);
	reg_host_model u_cfg_host (.clk_in(clk_in), .sel_out(cfg_sel_in), .wr_out(cfg_wr_in),
		.addr_out(cfg_addr_in), .be_out(cfg_be_in), .wdata_out(cfg_wdata_in),
		.rdata_in(cfg_rdata_out), .ack_in(cfg_ack_out));
	reg_host_model u_loc_host (.clk_in(clk_in), .sel_out(loc_sel_in), .wr_out(loc_wr_in),
		.addr_out(loc_addr_in), .be_out(loc_be_in), .wdata_out(loc_wdata_in),
		.rdata_in(loc_rdata_out), .ack_in(loc_ack_out));

	// Free-running 40 MHz clock.
	initial begin
		forever #12.5 clk_in = ~clk_in;
	end

	// Access and compare helpers.
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic crd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		u_cfg_host.xfer(1'b0, a, 4'hF, 32'h0, q);
		chk("config read", e, q);
	endtask
	task automatic lrd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		u_loc_host.xfer(1'b0, a, 4'hF, 32'h0, q);
		chk("local read", e, q);
	endtask
	task automatic wr(input logic lp, input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		if (lp) u_loc_host.xfer(1'b1, a, 4'hF, d, q);
		else u_cfg_host.xfer(1'b1, a, 4'hF, d, q);
	endtask
	task automatic dec(input logic [31:0] a, input logic io, input logic [3:0] e);
		@(negedge clk_in);
		bus_req_in = 1'b1;
		bus_addr_in = a;
		bus_is_io_in = io;
		@(negedge clk_in);
		bus_req_in = 1'b0;
		chk("claim", {28'h0, e}, {28'h0, claim_out});
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// Main sequence.
	initial begin
		repeat (12) @(negedge clk_in);
		srst_in = 1'b0;
		crd(8'h14, 32'h00000001);
		crd(8'h18, 32'h0000000A);
		crd(8'h1C, 32'h00000001);
		crd(8'h2C, {16'h0, SVID});
		for (int i = 0; i < 3; i++) begin
			wr(1'b0, 8'h20 + 8'(4 * i), 32'hFFFFFFFF);
			wr(1'b1, 8'h20 + 8'(4 * i), 32'hFFFFFFFF);
			lrd(8'h20 + 8'(4 * i), 32'h0);
			crd(8'h20 + 8'(4 * i), 32'h0);
		end
		wr(1'b0, 8'h14, 32'hFFFFFFFF);
		crd(8'h14, 32'hFFFFFF01);
		wr(1'b1, 8'h10, 32'hFFFFFFFF);
		crd(8'h10, 32'hFFFFFF00);
		wr(1'b0, 8'h18, 32'hFFFFFFFF);
		lrd(8'h18, 32'hFFFFFFFA);
		wr(1'b1, 8'h1C, 32'hFFFFFFFF);
		crd(8'h1C, 32'hFFFFFFFD);
		space0_range_cfg_in = 32'hFFFFFF01;
		crd(8'h18, 32'hFFFFFFF1);
		wr(1'b0, 8'h18, 32'hFFFFFFFF);
		crd(8'h18, 32'hFFFFFFFD);
		space0_range_cfg_in = 32'hFFFF000A;
		wr(1'b0, 8'h2C, 32'h0000BEEF);
		crd(8'h2C, {16'h0, SVID});
		wr(1'b1, 8'h2C, 32'h0000BEEF);
		crd(8'h2C, 32'h0000BEEF);
		eeprom_svid_load_in = 1'b1;
		@(negedge clk_in);
		eeprom_svid_load_in = 1'b0;
		chk("vendor id", 32'h1234, {16'h0, svid_out});
		message_queue_status_in = 32'h1;
		crd(8'h1C, 32'h0);
		lrd(8'h1C, 32'h0);
		message_queue_status_in = 32'h0;
		local_misc_control_one_in = 32'h1;
		space1_local_base_cfg_in = 32'h1;
		dec(32'hFFFFFF40, 1'b1, 4'hA);
		local_misc_control_one_in = 32'h0;
		dec(32'hFFFFFF40, 1'b1, 4'h8);
		space1_local_base_cfg_in = 32'h0;
		dec(32'hFFFFFF40, 1'b1, 4'h0);
		space0_local_base_cfg_in = 32'h1;
		dec(32'hFFFF1234, 1'b0, 4'h4);
		space0_range_cfg_in = 32'hFFFF0002;
		dec(32'hFFFF1234, 1'b0, 4'h4);
		space0_local_base_cfg_in = 32'h0;
		dec(32'hFFFF1234, 1'b0, 4'h0);
		dec(32'hFFFFFF20, 1'b0, 4'h1);
		srst_in = 1'b1;
		repeat (2) @(negedge clk_in);
		srst_in = 1'b0;
		crd(8'h14, 32'h00000001);
		crd(8'h2C, {16'h0, SVID});
		stop_test();
	end

	// Watchdog against a hung run.
	initial begin
		#125000;
		fail_count++;
		stop_test();
	end
endmodule

bind pci_bar_config_header pci_bar_config_header_sva u_pci_bar_config_header_sva (.*);
